// ### bench/eprom_model.sv
`timescale 1ns/1ps

// behavioural slave; cycle counts stand in for its analog delay circuit
module eprom_model #(
   parameter logic [55:0] SERIAL = 56'h0,
   parameter int SAMPLE = 1750,
   parameter int HOLD = 3200,
   parameter int RST_DET = 4000,
   parameter int PDH = 60,
   parameter int PDL = 600
) (
   // delay timebase
   input wire logic clk,
   // line
   input wire logic dq,
   output logic pull
);
   function automatic logic [7:0] crc8(input logic [55:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 56; i++) begin
         c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
      end
      return c;
   endfunction

   localparam logic [63:0] ID = {crc8(SERIAL), SERIAL};

   logic restart;
   logic g;
   logic lost;
   logic [7:0] cmd;

   // one slot; a low long enough to be a reset ends in presence instead
   task automatic xfer(input logic drive0, output logic got);
      int n;
      n = 0;
      got = 1'b1;
      if (!restart) begin
         @(negedge dq);
         pull <= drive0;
         do begin
            @(posedge clk);
            n++;
            if (n == SAMPLE) got = dq;
            if (n == HOLD) pull <= 1'b0;
         end while (n < RST_DET && !(n > HOLD && dq === 1'b1));
         if (n >= RST_DET) begin
            @(posedge dq);
            repeat (PDH) @(posedge clk);
            pull <= 1'b1;
            repeat (PDL) @(posedge clk);
            pull <= 1'b0;
            restart = 1'b1;
         end
      end
   endtask

   initial begin
      pull = 1'b0;
      restart = 1'b0;
      forever begin
         while (!restart) xfer(1'b0, g);
         restart = 1'b0;
         lost = 1'b0;
         for (int i = 0; i < 8; i++) begin
            xfer(1'b0, g);
            cmd[i] = g;
         end
         if (cmd == 8'h33) begin
            for (int i = 0; i < 64; i++) xfer(!ID[i], g);
         end else if (cmd == 8'hF0) begin
            for (int i = 0; i < 64 && !lost; i++) begin
               xfer(!ID[i], g);
               xfer(ID[i], g);
               xfer(1'b0, g);
               lost = (g !== ID[i]);
            end
         end else if (cmd == 8'h55) begin
            for (int i = 0; i < 64; i++) begin
               xfer(1'b0, g);
               lost = lost | (g !== ID[i]);
            end
         end
         // memory layer after a match or skip is not modelled
      end
   end
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
`include "line_master_regs.svh"

module testbench;
   localparam int RST_LOW = 5000;
   localparam int PROG = 3000;
   localparam int MAX_LOW = 4500;
   localparam int RST_HIGH = 5000;
   localparam int PRES_SAMP = 300;
   localparam int WR0_LOW = 2000;
   localparam int WR_SAMP = 1750;
   localparam int SLOT = 3500;
   localparam int RST_WIN = 10000;
   localparam int DEPTH = 8;
   // two resets, one written byte, two search steps and one program pulse come to about 91000 cycles
   localparam int LIMIT = 99000;
   // identities are arbitrary; bits 0 and 1 differ between the two
   localparam logic [55:0] SER_A = 56'h1234_5678_9ABC_02;
   localparam logic [55:0] SER_B = 56'h6543_2100_FEDC_01;

   logic clk, rst, cmd_valid, cmd_ready, res_valid, res_ready;
   logic dq_out, dq_oe, prog_en, pull_a, pull_b;
   logic [2:0] cmd_op;
   logic [7:0] cmd_data, res_data, r;
   logic [7:0] exp_q [$];
   logic [55:0] ser [2];
   logic act [2];
   int mismatches, compares, seed, cyc, prog_cnt, low_run;
   wire dq_line = ~((dq_oe & ~dq_out) | pull_a | pull_b);

   line_master #(.RESET_LOW_CYC(20'(RST_LOW)), .RESET_HIGH_CYC(20'(RST_HIGH)), .PRESENCE_SAMPLE_CYC(20'(PRES_SAMP)),
      .WRITE0_LOW_CYC(20'(WR0_LOW)), .WRITE_SAMPLE_CYC(20'(WR_SAMP)), .SLOT_CYC(20'(SLOT)), .PROGRAM_CYC(20'(PROG)),
      .MAX_LOW_CYC(20'(MAX_LOW)), .RESET_WINDOW_CYC(20'(RST_WIN)), .FIFO_DEPTH(DEPTH)) u_dut (
      .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
      .cmd_ready(cmd_ready), .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready),
      .dq_in(dq_line), .dq_out(dq_out), .dq_oe(dq_oe), .prog_en(prog_en));
   eprom_model #(.SERIAL(SER_A), .SAMPLE(WR_SAMP)) u_dev_a (.clk(clk), .dq(dq_line), .pull(pull_a));
   eprom_model #(.SERIAL(SER_B), .SAMPLE(WR_SAMP)) u_dev_b (.clk(clk), .dq(dq_line), .pull(pull_b));

   always #2 clk = ~clk;

   task automatic conclude;
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask

   task automatic chk_count(input logic [19:0] g, input logic [19:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask

   task automatic command(input logic [2:0] op, input logic [7:0] d);
      cmd_op <= op;
      cmd_data <= d;
      cmd_valid <= 1'b1;
      @(posedge clk);
      while (cmd_ready !== 1'b1) @(posedge clk);
      cmd_valid <= 1'b0;
      @(posedge clk);
      while (cmd_ready !== 1'b1) @(posedge clk);
   endtask

   // consumer stalls a random while before popping
   task automatic get_result(output logic [7:0] v);
      repeat (2 + ($random(seed) & 7)) @(posedge clk);
      while (res_valid !== 1'b1) @(posedge clk);
      v = res_data;
      res_ready <= 1'b1;
      @(posedge clk);
      res_ready <= 1'b0;
   endtask

   // reference search step over the devices still taking part
   task automatic trip(input int b);
      logic [7:0] rnd;
      logic idb, cmb, dir;
      rnd = 8'($random(seed));
      idb = 1'b1;
      cmb = 1'b1;
      for (int k = 0; k < 2; k++) begin
         if (act[k]) idb = idb & ser[k][b];
         if (act[k]) cmb = cmb & !ser[k][b];
      end
      dir = (idb != cmb) ? idb : rnd[0];
      for (int k = 0; k < 2; k++) if (ser[k][b] != dir) act[k] = 1'b0;
      command(`OP_TRIPLET, rnd);
      exp_q.push_back({5'h00, dir, cmb, idb});
   endtask

   // results wait in the design's queue; pop them all in order, then it must stand empty
   task automatic drain;
      int n;
      int nexp;
      logic [7:0] e;
      n = 0;
      nexp = exp_q.size();
      while (res_valid === 1'b1 && n < DEPTH) begin
         get_result(r);
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hFF;
         chk_byte(r, e);
         n++;
         @(posedge clk);
      end
      chk_count(20'(n), 20'(nexp));
      chk_byte({7'h00, res_valid}, 8'h00);
   endtask

   // wire watch: no long low except an exact reset, no pull during programming
   always @(posedge clk) begin
      cyc++;
      if (prog_en === 1'b1) prog_cnt++;
      if (prog_en === 1'b1) chk_byte({7'h00, dq_oe}, 8'h00);
      if (dq_oe === 1'b1) low_run++;
      else begin
         if (low_run > MAX_LOW) chk_count(20'(low_run), 20'(RST_LOW));
         low_run = 0;
      end
      if (cyc == LIMIT) begin
         mismatches++;
         conclude;
      end
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = 3'h0;
      cmd_data = 8'h00;
      res_ready = 1'b0;
      mismatches = 0;
      compares = 0;
      seed = 2;
      cyc = 0;
      prog_cnt = 0;
      low_run = 0;
      ser[0] = SER_A;
      ser[1] = SER_B;
      act[0] = 1'b1;
      act[1] = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk_byte({4'h0, cmd_ready, res_valid, dq_oe, prog_en}, 8'h00);
      command(`OP_RESET, 8'h00);
      exp_q.push_back(8'h01);
      command(`OP_WRITE_BYTE, 8'hF0);
      trip(0);
      trip(1);
      drain;
      prog_cnt = 0;
      command(`OP_PROGRAM, 8'h00);
      chk_count(20'(prog_cnt), 20'(PROG));
      command(`OP_RESET, 8'h00);
      exp_q.push_back(8'h01);
      drain;
      conclude;
   end
endmodule

// ### verilog/line_master.sv
`timescale 1ns/1ps
`include "line_master_regs.svh"

// How it works
// (RL1) match command plus 64 identity bits selects device
// (RL2) mismatched device ignores bus until reset
// (RL3) skip command goes straight to memory command
// (RL4) search: read bit, read complement, write bit
// (RL5) search loser drops out until next reset
// (RL6) master holds reset low, releases, listens presence
// (RL7) device waits, then pulls presence low
// (RL8) first byte after presence is address command
// (RL9) reset low plus recovery under 960 us
// (RL10) every slot starts with master falling edge
// (RL11) device samples write slot after internal delay
// (RL12) device pulls low for zero, releases for one
// (RL13) read zero valid 1 us to 15 us
// (RL14) never hold line low over 120 us
// (RL15) after good crc, 480 us program pulse, idle
// (RL16) program pulse copies scratchpad into eprom
// (RL17) read identity: family, serial, then crc
// (RL18) identity crc over 56 bits, x8+x5+x4+1
// (RL19) identity crc true, 16-bit crcs inverted
// (RL20) 16-bit crc x16+x15+x2+1 guards transfers
// (RL21) plain memory read: one crc at end
// (RL22) status read: crc after each 8-byte page
// (RL23) later status pages: crc over page only
// (RL24) extended read: crc after each redirection byte
// (RL25) extended read: crc after each data page
// (RL26) reset and presence abandon any command
module line_master #(
   parameter logic [19:0] RESET_LOW_CYC = 20'(`US_MIN_CYC(`RESET_LOW_TIME_US)),
   parameter logic [19:0] RESET_HIGH_CYC = 20'(`US_MIN_CYC(`RESET_HIGH_TIME_US)),
   parameter logic [19:0] PRESENCE_SAMPLE_CYC = 20'(`US_MIN_CYC(`PRESENCE_SAMPLE_US)),
   parameter logic [19:0] WRITE0_LOW_CYC = 20'(`US_MIN_CYC(`WRITE0_LOW_US)),
   parameter logic [19:0] WRITE_SAMPLE_CYC = 20'(`US_MIN_CYC(`WRITE_SAMPLE_US)),
   parameter logic [19:0] SLOT_CYC = 20'(`US_MIN_CYC(`SLOT_US)),
   parameter logic [19:0] PROGRAM_CYC = 20'(`US_MIN_CYC(`PROGRAM_PULSE_US)),
   parameter logic [19:0] MAX_LOW_CYC = 20'(`US_MAX_CYC(`MAX_LOW_US)),
   parameter logic [19:0] RESET_WINDOW_CYC = 20'(`US_MAX_CYC(`RESET_WINDOW_US)),
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // command port
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_op,
   input wire logic [7:0] cmd_data,
   output logic cmd_ready,
   // result port
   output logic res_valid,
   output logic [7:0] res_data,
   input wire logic res_ready,
   // single-wire line, open drain
   input wire logic dq_in,
   output logic dq_out,
   output logic dq_oe,
   // programming supply enable
   output logic prog_en
);

   localparam logic [19:0] WRITE1_LOW_CYC = 20'(`US_MIN_CYC(`WRITE1_LOW_US));
   localparam logic [19:0] READ_LOW_CYC = 20'(`US_MIN_CYC(`READ_LOW_US));
   localparam logic [19:0] READ_SAMPLE_CYC = 20'(`US_MAX_CYC(`READ_SAMPLE_US));
   localparam logic [19:0] RECOVERY_CYC = 20'(`US_MIN_CYC(`RECOVERY_US));
   localparam logic [19:0] SLOT_END = SLOT_CYC + RECOVERY_CYC - 20'h1;
   localparam logic [19:0] PRESENCE_AT = RESET_LOW_CYC + PRESENCE_SAMPLE_CYC;
   localparam logic [19:0] RESET_END = RESET_LOW_CYC + RESET_HIGH_CYC - 20'h1;
   localparam logic [19:0] PROGRAM_END = PROGRAM_CYC + RECOVERY_CYC - 20'h1;

   line_master_pkg::state_t state_r;
   logic [`COUNT_WIDTH-1:0] cnt_r;
   logic [2:0] op_r;
   logic [7:0] shift_r;
   logic [2:0] bit_idx_r;
   logic [1:0] phase_r;
   logic id_bit_r;
   logic cmp_bit_r;
   logic samp_r;
   logic dq_s1_r;
   logic dq_s2_r;
   logic push_valid_r;
   logic [7:0] push_data_r;
   logic fifo_in_ready;
   logic slot_read;
   logic slot_wbit;
   logic [19:0] slot_low;

   // ----------------------------------------
   // slot decoding
   // ----------------------------------------
   function automatic logic is_read(input logic [2:0] op, input logic [1:0] phase);
      is_read = (op == `OP_READ_BYTE) || (op == `OP_TRIPLET && phase != `TRIPLET_WRITE_PHASE);
   endfunction

   // direction chosen in a search step: a lone answer wins, a collision takes the caller's pick
   function automatic logic search_dir(input logic id, input logic cmp, input logic pick);
      search_dir = (id != cmp) ? id : pick;
   endfunction

   function automatic logic [19:0] low_time(input logic rd, input logic wbit);
      low_time = rd ? READ_LOW_CYC : (wbit ? WRITE1_LOW_CYC : WRITE0_LOW_CYC);
   endfunction

   assign slot_read = is_read(op_r, phase_r);
   assign slot_wbit = (op_r == `OP_TRIPLET) ? search_dir(id_bit_r, cmp_bit_r, shift_r[0]) : shift_r[0]; // [RL4]
   assign slot_low = low_time(slot_read, slot_wbit);

   // ----------------------------------------
   // line input synchroniser
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dq_s1_r <= 1'b1;
         dq_s2_r <= 1'b1;
      end else begin
         dq_s1_r <= dq_in;
         dq_s2_r <= dq_s1_r;
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= line_master_pkg::ST_IDLE;
         cnt_r <= '0;
         op_r <= `OP_RESET;
         shift_r <= 8'h00;
         bit_idx_r <= 3'h0;
         phase_r <= 2'h0;
         id_bit_r <= 1'b0;
         cmp_bit_r <= 1'b0;
         samp_r <= 1'b0;
         cmd_ready <= 1'b0;
         push_valid_r <= 1'b0;
         push_data_r <= 8'h00;
      end else begin
         case (state_r)
            line_master_pkg::ST_IDLE: begin
               cnt_r <= '0;
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  op_r <= cmd_op;
                  shift_r <= cmd_data;
                  bit_idx_r <= 3'h0;
                  phase_r <= 2'h0;
                  if (cmd_op == `OP_RESET) begin
                     state_r <= line_master_pkg::ST_RST;
                  end else if (cmd_op == `OP_PROGRAM) begin
                     state_r <= line_master_pkg::ST_PROG;
                  end else begin
                     state_r <= line_master_pkg::ST_SLOT;
                  end
               end
            end
            line_master_pkg::ST_RST: begin
               cnt_r <= cnt_r + 20'h1;
               // device answers within its wait plus low window, so one late sample catches it
               if (cnt_r == PRESENCE_AT) begin
                  samp_r <= !dq_s2_r; // [RL6] [RL7]
               end
               if (cnt_r == RESET_END) begin
                  push_data_r <= {7'h00, samp_r};
                  push_valid_r <= 1'b1;
                  state_r <= line_master_pkg::ST_PUSH;
               end
            end
            line_master_pkg::ST_SLOT: begin
               cnt_r <= cnt_r + 20'h1;
               if (slot_read && cnt_r == READ_SAMPLE_CYC) begin
                  samp_r <= dq_s2_r; // [RL13]
               end
               if (cnt_r == SLOT_END) begin
                  cnt_r <= '0;
                  case (op_r)
                     `OP_READ_BYTE: begin
                        shift_r <= {samp_r, shift_r[7:1]};
                        bit_idx_r <= bit_idx_r + 3'h1;
                        if (bit_idx_r == `LAST_BIT) begin
                           push_data_r <= {samp_r, shift_r[7:1]};
                           push_valid_r <= 1'b1;
                           state_r <= line_master_pkg::ST_PUSH;
                        end
                     end
                     `OP_TRIPLET: begin
                        phase_r <= phase_r + 2'h1;
                        if (phase_r == 2'h0) begin
                           id_bit_r <= samp_r;
                        end else if (phase_r == 2'h1) begin
                           cmp_bit_r <= samp_r;
                        end else begin
                           push_data_r <= {5'h00, slot_wbit, cmp_bit_r, id_bit_r}; // [RL4]
                           push_valid_r <= 1'b1;
                           state_r <= line_master_pkg::ST_PUSH;
                        end
                     end
                     default: begin
                        shift_r <= {1'b0, shift_r[7:1]};
                        bit_idx_r <= bit_idx_r + 3'h1;
                        if (bit_idx_r == `LAST_BIT) begin
                           state_r <= line_master_pkg::ST_IDLE;
                        end
                     end
                  endcase
               end
            end
            line_master_pkg::ST_PROG: begin
               cnt_r <= cnt_r + 20'h1;
               if (cnt_r == PROGRAM_END) begin
                  state_r <= line_master_pkg::ST_IDLE;
               end
            end
            line_master_pkg::ST_PUSH: begin
               // a full queue stalls here and holds the command port closed
               if (fifo_in_ready) begin
                  push_valid_r <= 1'b0;
                  state_r <= line_master_pkg::ST_IDLE;
               end
            end
            default: begin
               state_r <= line_master_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // line drivers
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dq_oe <= 1'b0;
         dq_out <= 1'b0;
         prog_en <= 1'b0;
      end else begin
         dq_out <= 1'b0;
         dq_oe <= (state_r == line_master_pkg::ST_RST && cnt_r < RESET_LOW_CYC) || // [RL6] [RL9]
                  (state_r == line_master_pkg::ST_SLOT && cnt_r < slot_low); // [RL10] [RL14]
         // software must check the byte's crc before asking for this pulse
         prog_en <= (state_r == line_master_pkg::ST_PROG && cnt_r < PROGRAM_CYC); // [RL15]
      end
   end

   result_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(push_valid_r),
      .in_data(push_data_r),
      .in_ready(fifo_in_ready),
      .out_valid(res_valid),
      .out_data(res_data),
      .out_ready(res_ready)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [19:0] low_run_r;
   logic [19:0] prog_run_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_run_r <= '0;
         prog_run_r <= '0;
      end else begin
         low_run_r <= dq_oe ? low_run_r + 20'h1 : 20'h0;
         prog_run_r <= prog_en ? prog_run_r + 20'h1 : 20'h0;
      end
   end

   sequence slot_open;
      state_r == line_master_pkg::ST_SLOT && cnt_r == 20'h0;
   endsequence

   sequence triplet_write;
      state_r == line_master_pkg::ST_SLOT && op_r == `OP_TRIPLET && phase_r == `TRIPLET_WRITE_PHASE;
   endsequence

   slot_falls_a: assert property (@(posedge clk) disable iff (rst) // [RL10]
      slot_open |=> dq_oe [*2]) else $error("slot did not open with a low pulse");

   search_dir_a: assert property (@(posedge clk) disable iff (rst) // [RL4]
      triplet_write and (id_bit_r != cmp_bit_r) |-> (slot_wbit == id_bit_r) && (slot_low == low_time(1'b0, id_bit_r)))
      else $error("search step wrote wrong direction");

   write_level_a: assert property (@(posedge clk) disable iff (rst) // [RL11]
      state_r == line_master_pkg::ST_SLOT && !slot_read && cnt_r == WRITE_SAMPLE_CYC |-> dq_oe == !slot_wbit)
      else $error("write slot shows wrong level at sample time");

   reset_long_a: assert property (@(posedge clk) disable iff (rst) // [RL6]
      $fell(dq_oe) && state_r == line_master_pkg::ST_RST |-> $past(low_run_r) >= RESET_LOW_CYC - 20'h1)
      else $error("reset pulse too short");

   reset_window_a: assert property (@(posedge clk) disable iff (rst) // [RL9]
      state_r == line_master_pkg::ST_RST |-> low_run_r < RESET_WINDOW_CYC)
      else $error("reset low too long");

   low_limit_a: assert property (@(posedge clk) disable iff (rst) // [RL14]
      dq_oe && state_r != line_master_pkg::ST_RST |-> low_run_r < MAX_LOW_CYC)
      else $error("line held low too long");

   prog_width_a: assert property (@(posedge clk) disable iff (rst) // [RL15]
      $fell(prog_en) |-> prog_run_r >= PROGRAM_CYC && !dq_oe)
      else $error("program pulse too short");

endmodule

// ### verilog/line_master_pkg.sv
package line_master_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RST,
      ST_SLOT,
      ST_PROG,
      ST_PUSH
   } state_t;

endpackage

// ### verilog/line_master_regs.svh
`ifndef LINE_MASTER_REGS_SVH
`define LINE_MASTER_REGS_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define CLK_PERIOD_NS 4

// least time in microseconds to cycles, rounded up
`define US_MIN_CYC(us) ((((us) * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// longest time in microseconds to cycles, rounded down
`define US_MAX_CYC(us) (((us) * 1000) / `CLK_PERIOD_NS)

// ----------------------------------------
// line timing, microseconds
// ----------------------------------------
`define RESET_LOW_TIME_US 480
`define RESET_HIGH_TIME_US 480
`define RESET_WINDOW_US 960
`define PRESENCE_WAIT_TIME_MAX_US 60
`define PRESENCE_SAMPLE_US 70
`define WRITE0_LOW_US 60
`define WRITE1_LOW_US 6
`define READ_LOW_US 2
`define READ_SAMPLE_US 12
`define WRITE_SAMPLE_US 30
`define SLOT_US 70
`define RECOVERY_US 5
`define PROGRAM_PULSE_US 480
`define MAX_LOW_US 120

// ----------------------------------------
// command codes on the user port
// ----------------------------------------
`define OP_RESET 3'h0
`define OP_WRITE_BYTE 3'h1
`define OP_READ_BYTE 3'h2
`define OP_TRIPLET 3'h3
`define OP_PROGRAM 3'h4

`define LAST_BIT 3'h7
`define TRIPLET_WRITE_PHASE 2'h2
`define COUNT_WIDTH 20

`endif

// ### verilog/result_fifo.sv
`timescale 1ns/1ps

// shift-style queue: entry 0 is always the head, so the read side comes straight from flops
module result_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);

   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_r[0];

   always_comb begin
      count_nxt = count_r;
      if (push && !pop) begin
         count_nxt = count_r + CW'(1);
      end else if (pop && !push) begin
         count_nxt = count_r - CW'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_r <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         count_r <= count_nxt;
         in_ready <= (count_nxt != CW'(DEPTH));
         out_valid <= (count_nxt != '0);
      end
   end

   genvar i;
   generate
      for (i = 0; i < DEPTH; i++) begin : g_entry
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               mem_r[i] <= '0;
            end else if (pop) begin
               if (push && (CW'(i) == count_r - CW'(1))) begin
                  mem_r[i] <= in_data;
               end else if (i < DEPTH - 1) begin
                  mem_r[i] <= mem_r[(i < DEPTH - 1) ? i + 1 : i];
               end
            end else if (push && (CW'(i) == count_r)) begin
               mem_r[i] <= in_data;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // checks
   // ----------------------------------------
   fifo_bound_a: assert property (@(posedge clk) disable iff (rst) // [RL4]
      count_r <= CW'(DEPTH)) else $error("queue holds more than its depth");

   fifo_full_a: assert property (@(posedge clk) disable iff (rst) // [RL4]
      in_ready == (count_r != CW'(DEPTH))) else $error("queue ready disagrees with its fill");

endmodule
